/* verilog/sprx_pkg.sv */
/*
 * sprx_pkg: register offsets, field positions, reset values and
 * fixed sizes for the receiver input and status block.
 * Assumes the host register port uses 8-bit addresses and data.
 */
`default_nettype none

package sprx_pkg;

  // register offsets
  localparam logic [7:0] OFS_RX_INPUT_MODE = 8'h24;
  localparam logic [7:0] OFS_PIN_CONFIG_B = 8'h27;
  localparam logic [7:0] OFS_PIN_CONFIG_C = 8'h28;
  localparam logic [7:0] OFS_CS_BASE = 8'h2c;
  localparam logic [7:0] OFS_CS_LAST = 8'h30;
  localparam logic [7:0] OFS_CS_UPDATE = 8'h31;
  localparam logic [7:0] OFS_POWER_DOWN_B = 8'h33;

  // field positions
  localparam int POS_TYPE_SEL = 0;
  localparam int POS_SRC_SEL = 1;
  localparam int POS_TRUNC_MASK = 6;
  localparam int POS_RX_PD = 5;
  localparam int POS_CS_NONAUDIO = 1;
  localparam int POS_CS_PREEMPH = 3;
  localparam int POS_CS_MAXLEN = 32;
  localparam int POS_CS_LENCODE = 33;

  // reset values
  localparam logic [7:0] RST_RX_INPUT_MODE = 8'h01;
  localparam logic [7:0] RST_PIN_CONFIG_B = 8'h32;
  localparam logic [7:0] RST_PIN_CONFIG_C = 8'h04;
  localparam logic [7:0] RST_POWER_DOWN_B = 8'h20;

  // pin configuration codes for receiver use
  localparam logic [3:0] CFG_RX_CMOS = 4'he;
  localparam logic [3:0] CFG_RX_COMP = 4'hf;

  // sub-frame layout and sizes
  localparam int SF_SAMPLE_LO = 4;
  localparam int SF_SAMPLE_HI = 27;
  localparam int SF_VALID = 28;
  localparam int SF_USER = 29;
  localparam int SF_CHSTAT = 30;
  localparam int SF_PARITY = 31;
  localparam int SAMPLE_W = 24;
  localparam int CS_BITS = 40;
  localparam int FIFO_DEPTH = 8;

  // audio interface word length codes
  localparam logic [1:0] AIF_LEN_16 = 2'h0;
  localparam logic [1:0] AIF_LEN_20 = 2'h1;
  localparam logic [1:0] AIF_LEN_24 = 2'h2;
  localparam logic [1:0] AIF_LEN_32 = 2'h3;

endpackage : sprx_pkg

`default_nettype wire

/* verilog/sprx_fifo.sv */
/*
 * sprx_fifo: small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset; full and
 * empty are registered so in_ready_o and out_valid_o come from flops.
 */
`timescale 1ns/1ps
`default_nettype none

module sprx_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // write side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // read side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data_o = mem[rptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      wptr <= push ? AW'(wptr + 1'b1) : wptr;
      rptr <= pop ? AW'(rptr + 1'b1) : rptr;
      count <= next_count;
      in_ready_o <= (next_count != (AW+1)'(DEPTH));
      out_valid_o <= (next_count != '0);
    end
  end

endmodule : sprx_fifo

`default_nettype wire

/* verilog/sprx_core.sv */
/*
 * sprx_core: input selection, sub-frame data handling and channel
 * status capture of the consumer digital audio receiver.
 * Assumes the line decoder delivers one 32-slot sub-frame per pulse on
 * sf_valid_i, with channel and block-start marks, all on clk_i.
 */
// Summary of operation
// - primary input uses comparator when type bit is 1, else CMOS
// - two-bit selector, reset 00, routes one of four inputs
// - pin config 1110 makes CMOS input, 1111 comparator input
// - receiver off while power-down bit 5 is 1, its reset value
// - each sub-frame yields payload plus validity, user, status, parity
// - linear audio samples can feed the first DAC
// - non-audio stream mutes the DAC fed by the receiver
// - samples go to audio interfaces alongside DAC playback
// - samples can also go to the on-chip transmitter
// - recovered user bits are offered for output pins
// - sample is always payload bits 4 to 27, 24 bits
// - mask bit clear truncates to status length, set passes 24 bits
// - shorter interface word drops low bits, always
// - longer interface word gets sample left-aligned, zero filled
// - transmitter gets full 24 bits unless truncation is active
// - pre-emphasis with DAC routing turns on DAC de-emphasis
// - status from channel 1 only, in five read-only registers
// - update flag set on new status, cleared by readback
// - update flag is offered for output pins
// - status bit 3 reports pre-emphasis
`timescale 1ns/1ps
`default_nettype none

module sprx_core (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // receiver input pins
  input wire logic primary_rx_input_i,
  input wire logic second_rx_input_i,
  input wire logic third_rx_input_i,
  input wire logic fourth_rx_input_i,
  // front end and decoder control
  output logic primary_comp_en_o,
  output logic [2:0] multi_pin_rx_en_o,
  output logic [2:0] multi_pin_comp_en_o,
  output logic rx_enable_o,
  output logic rx_line_o,
  // decoded sub-frames
  input wire logic sf_valid_i,
  input wire logic [31:0] sf_word_i,
  input wire logic sf_chan2_i,
  input wire logic sf_block_i,
  output logic sf_ready_o,
  // routing and interface word length
  input wire logic route_dac_i,
  input wire logic [1:0] aif_len_i,
  // sample outputs
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic out_chan2_o,
  output logic [23:0] dac_data_o,
  output logic [31:0] aif_data_o,
  output logic [23:0] tx_data_o,
  // sub-frame flags and status outputs
  output logic validity_o,
  output logic user_bit_o,
  output logic parity_err_o,
  output logic dac_mute_o,
  output logic dac_pre_emphasis_flag_o,
  output logic status_update_o
);

  import sprx_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // control registers

  logic [7:0] rx_input_mode;
  logic [7:0] pin_config_b;
  logic [7:0] pin_config_c;
  logic [7:0] power_down_b;
  logic [CS_BITS-1:0] cs_regs;
  logic [CS_BITS-1:0] cs_shadow;
  logic [7:0] cs_count;
  logic status_update_flag;

  wire wr_mode = reg_we_i && (reg_addr_i == OFS_RX_INPUT_MODE);
  wire wr_cfg_b = reg_we_i && (reg_addr_i == OFS_PIN_CONFIG_B);
  wire wr_cfg_c = reg_we_i && (reg_addr_i == OFS_PIN_CONFIG_C);
  wire wr_pwr = reg_we_i && (reg_addr_i == OFS_POWER_DOWN_B);
  wire rd_update = reg_re_i && (reg_addr_i == OFS_CS_UPDATE);

  wire primary_input_type_sel = rx_input_mode[POS_TYPE_SEL];
  wire [1:0] rx_source_select = rx_input_mode[POS_SRC_SEL +: 2];
  wire truncation_mask = rx_input_mode[POS_TRUNC_MASK];
  wire receiver_power_down = power_down_b[POS_RX_PD];
  wire [3:0] pin_b_config = pin_config_b[3:0];
  wire [3:0] pin_c_config = pin_config_b[7:4];
  wire [3:0] pin_d_config = pin_config_c[3:0];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_input_mode <= RST_RX_INPUT_MODE;
      pin_config_b <= RST_PIN_CONFIG_B;
      pin_config_c <= RST_PIN_CONFIG_C;
      power_down_b <= RST_POWER_DOWN_B;
    end else begin
      if (wr_mode) begin
        rx_input_mode <= reg_wdata_i;
      end
      if (wr_cfg_b) begin
        pin_config_b <= reg_wdata_i;
      end
      if (wr_cfg_c) begin
        pin_config_c <= reg_wdata_i;
      end
      if (wr_pwr) begin
        power_down_b <= reg_wdata_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register readback

  wire cs_hit = (reg_addr_i >= OFS_CS_BASE) && (reg_addr_i <= OFS_CS_LAST);
  wire [2:0] cs_idx = 3'(reg_addr_i - OFS_CS_BASE);
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (cs_hit) begin
      next_rdata = cs_regs[8*cs_idx +: 8];
    end else begin
      unique case (reg_addr_i)
        OFS_RX_INPUT_MODE: next_rdata = rx_input_mode;
        OFS_PIN_CONFIG_B: next_rdata = pin_config_b;
        OFS_PIN_CONFIG_C: next_rdata = pin_config_c;
        OFS_POWER_DOWN_B: next_rdata = power_down_b;
        OFS_CS_UPDATE: next_rdata = {7'h00, status_update_flag};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_re_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // input selector and front ends

  // pin is usable only once software set a receiver-input code
  function automatic logic cfg_is_rx(input logic [3:0] cfg);
    return (cfg == CFG_RX_CMOS) || (cfg == CFG_RX_COMP);
  endfunction

  wire [2:0] pin_rx_ok = {cfg_is_rx(pin_d_config),
                          cfg_is_rx(pin_c_config),
                          cfg_is_rx(pin_b_config)};
  wire [2:0] pin_comp = {pin_d_config == CFG_RX_COMP,
                         pin_c_config == CFG_RX_COMP,
                         pin_b_config == CFG_RX_COMP};
  logic sel_line;
  logic sel_ok;

  always_comb begin
    unique case (rx_source_select)
      2'h0: begin
        sel_line = primary_rx_input_i;
        sel_ok = 1'b1;
      end
      2'h1: begin
        sel_line = second_rx_input_i;
        sel_ok = pin_rx_ok[0];
      end
      2'h2: begin
        sel_line = third_rx_input_i;
        sel_ok = pin_rx_ok[1];
      end
      2'h3: begin
        sel_line = fourth_rx_input_i;
        sel_ok = pin_rx_ok[2];
      end
    endcase
  end

  wire rx_on = !receiver_power_down;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      primary_comp_en_o <= 1'b1;
      multi_pin_rx_en_o <= 3'h0;
      multi_pin_comp_en_o <= 3'h0;
      rx_enable_o <= 1'b0;
      rx_line_o <= 1'b0;
    end else begin
      primary_comp_en_o <= primary_input_type_sel;
      multi_pin_rx_en_o <= pin_rx_ok;
      multi_pin_comp_en_o <= pin_comp;
      rx_enable_o <= rx_on;
      // unconfigured pin gives a quiet line
      rx_line_o <= rx_on && sel_ok && sel_line;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // sub-frame fields and truncation

  wire [23:0] raw_sample = sf_word_i[SF_SAMPLE_HI:SF_SAMPLE_LO];
  wire cs_maxlen = cs_regs[POS_CS_MAXLEN];
  wire [2:0] cs_lencode = cs_regs[POS_CS_LENCODE +: 3];
  logic [4:0] drop_bits;

  // length decode, drop count against 24 bits
  always_comb begin
    unique case (cs_lencode)
      3'h1: drop_bits = 5'h04;
      3'h2: drop_bits = 5'h02;
      3'h4: drop_bits = 5'h01;
      3'h5: drop_bits = 5'h00;
      3'h6: drop_bits = 5'h03;
      default: drop_bits = 5'h00;
    endcase
  end

  wire lencode_known = (cs_lencode == 3'h1) || (cs_lencode == 3'h2) ||
                       (cs_lencode == 3'h4) || (cs_lencode == 3'h5) ||
                       (cs_lencode == 3'h6);
  // a 20-bit maximum shifts every length down by four
  wire [4:0] drop_total = (lencode_known && !cs_maxlen) ?
                          5'(drop_bits + 5'h04) : drop_bits;
  wire [23:0] trunc_keep = 24'hffffff << drop_total;
  wire [23:0] sample = truncation_mask ? raw_sample
                                       : (raw_sample & trunc_keep);
  wire sf_take = sf_valid_i && sf_ready_o && rx_on;

  //////////////////////////////////////////////////////////////////////
  // sample buffer

  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [SAMPLE_W:0] fifo_out_data;

  sprx_fifo #(
    .WIDTH(SAMPLE_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .in_valid_i(sf_valid_i && rx_on),
    .in_ready_o(sf_ready_o),
    .in_data_i({sf_chan2_i, sample}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // output stage refills whenever empty or being drained
  assign fifo_out_ready = !out_valid_o || out_ready_i;
  wire out_load = fifo_out_valid && fifo_out_ready;
  wire [23:0] buf_sample = fifo_out_data[SAMPLE_W-1:0];
  logic [31:0] aif_keep;

  always_comb begin
    unique case (aif_len_i)
      AIF_LEN_16: aif_keep = 32'hffff0000;
      AIF_LEN_20: aif_keep = 32'hfffff000;
      AIF_LEN_24: aif_keep = 32'hffffff00;
      AIF_LEN_32: aif_keep = 32'hffffffff;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out_valid_o <= 1'b0;
      out_chan2_o <= 1'b0;
      dac_data_o <= 24'h000000;
      aif_data_o <= 32'h00000000;
      tx_data_o <= 24'h000000;
    end else begin
      if (out_load) begin
        out_chan2_o <= fifo_out_data[SAMPLE_W];
        dac_data_o <= buf_sample;
        // left-aligned, low bits dropped or zeroed
        aif_data_o <= {buf_sample, 8'h00} & aif_keep;
        tx_data_o <= buf_sample;
      end
      out_valid_o <= out_load || (out_valid_o && !out_ready_i);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // per sub-frame flags

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      validity_o <= 1'b0;
      user_bit_o <= 1'b0;
      parity_err_o <= 1'b0;
    end else if (sf_take) begin
      validity_o <= sf_word_i[SF_VALID];
      // user bit for the pin multiplexer
      user_bit_o <= sf_word_i[SF_USER];
      parity_err_o <= ^sf_word_i[SF_PARITY:SF_SAMPLE_LO];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // channel status capture

  wire cs_take = sf_take && !sf_chan2_i;
  wire cs_commit = cs_take && sf_block_i && (cs_count >= 8'(CS_BITS));
  wire [7:0] cs_pos = sf_block_i ? 8'h00 : cs_count;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cs_shadow <= '0;
      cs_count <= 8'h00;
    end else if (cs_take) begin
      if (cs_pos < 8'(CS_BITS)) begin
        cs_shadow[6'(cs_pos)] <= sf_word_i[SF_CHSTAT];
      end
      cs_count <= (cs_pos == 8'hff) ? cs_pos : 8'(cs_pos + 8'h01);
    end
  end

  // whole block copied in one cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cs_regs <= '0;
    end else if (cs_commit) begin
      cs_regs <= cs_shadow;
    end
  end

  // set wins over clear by readback
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_update_flag <= 1'b0;
    end else if (cs_commit) begin
      status_update_flag <= 1'b1;
    end else if (rd_update) begin
      status_update_flag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // status driven outputs

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dac_mute_o <= 1'b0;
      dac_pre_emphasis_flag_o <= 1'b0;
      status_update_o <= 1'b0;
    end else begin
      dac_mute_o <= route_dac_i && cs_regs[POS_CS_NONAUDIO];
      dac_pre_emphasis_flag_o <= route_dac_i && cs_regs[POS_CS_PREEMPH];
      status_update_o <= status_update_flag;
    end
  end

endmodule : sprx_core

`default_nettype wire

/* verif/sprx_core_checker.sv */
/*
 * sprx_core_checker: port-level assertions for sprx_core.
 * Assumes it is bound to every sprx_core instance, single clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module sprx_core_checker
  import sprx_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [2:0] multi_pin_rx_en_o,
  input wire logic [2:0] multi_pin_comp_en_o,
  input wire logic rx_enable_o,
  input wire logic rx_line_o,
  input wire logic sf_valid_i,
  input wire logic [31:0] sf_word_i,
  input wire logic sf_ready_o,
  input wire logic route_dac_i,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic [23:0] dac_data_o,
  input wire logic [31:0] aif_data_o,
  input wire logic [23:0] tx_data_o,
  input wire logic validity_o,
  input wire logic user_bit_o,
  input wire logic parity_err_o,
  input wire logic dac_mute_o,
  input wire logic dac_pre_emphasis_flag_o,
  input wire logic status_update_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_take;
    sf_valid_i && sf_ready_o && rx_enable_o;
  endsequence
  // no commit may land in the read cycle, set wins over clear
  sequence s_flag_read;
    reg_re_i && reg_addr_i == OFS_CS_UPDATE && !sf_valid_i;
  endsequence

  sf_bits_a: assert property (s_take |=>
    validity_o == $past(sf_word_i[SF_VALID]) &&
    user_bit_o == $past(sf_word_i[SF_USER]) &&
    parity_err_o == ^$past(sf_word_i[31:4]))
    else $error("sub-frame flags wrong");
  sample_out_a: assert property (s_take |-> ##[1:2] out_valid_o)
    else $error("sample did not appear");
  out_hold_a: assert property (out_valid_o && !out_ready_i |=>
    out_valid_o && $stable(dac_data_o) && $stable(aif_data_o))
    else $error("output changed while stalled");
  tx_same_a: assert property (out_valid_o |-> tx_data_o == dac_data_o)
    else $error("transmit word differs");
  aif_align_a: assert property (out_valid_o |->
    aif_data_o[31:16] == dac_data_o[23:8] && aif_data_o[7:0] == 8'h00)
    else $error("interface word misaligned");
  dac_gate_a: assert property (dac_mute_o || dac_pre_emphasis_flag_o |->
    $past(route_dac_i))
    else $error("dac control without routing");
  pin_comp_a: assert property (
    (multi_pin_comp_en_o & ~multi_pin_rx_en_o) == 3'h0)
    else $error("comparator on non-input pin");
  line_off_a: assert property (
    !rx_enable_o && $past(!rx_enable_o) |-> !rx_line_o)
    else $error("line active while off");
  flag_clear_a: assert property (s_flag_read |=>
    reg_rdata_o[7:1] == 7'h00 ##1 !status_update_o)
    else $error("update flag not cleared");
endmodule : sprx_core_checker

bind sprx_core sprx_core_checker i_chk (.clk_i, .srst_i, .reg_addr_i,
  .reg_re_i, .reg_rdata_o, .multi_pin_rx_en_o, .multi_pin_comp_en_o,
  .rx_enable_o, .rx_line_o, .sf_valid_i, .sf_word_i, .sf_ready_o,
  .route_dac_i, .out_valid_o, .out_ready_i, .dac_data_o, .aif_data_o,
  .tx_data_o, .validity_o, .user_bit_o, .parity_err_o, .dac_mute_o,
  .dac_pre_emphasis_flag_o, .status_update_o);

`default_nettype wire

/* verif/sprx_src_model.sv */
/*
 * sprx_src_model: stream source handing decoded sub-frames to the block.
 * Assumes the caller enters send at a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module sprx_src_model (
  // clock
  input wire logic clk_i,
  // decoded sub-frame side
  output logic sf_valid_o,
  output logic [31:0] sf_word_o,
  output logic sf_chan2_o,
  output logic sf_block_o,
  input wire logic sf_ready_i
);
  initial begin
    sf_valid_o = 1'b0;
    sf_word_o = 32'h0;
    sf_chan2_o = 1'b0;
    sf_block_o = 1'b0;
  end

  // length fields ride in the status slot the caller fills
  // gap sets how slowly the source offers the next sub-frame
  task automatic send(input logic [31:0] w, input logic c2,
                      input logic blk, input int gap);
    sf_word_o <= w;
    sf_chan2_o <= c2;
    sf_block_o <= blk;
    sf_valid_o <= 1'b1;
    @(posedge clk_i);
    while (!sf_ready_i) @(posedge clk_i);
    sf_valid_o <= 1'b0;
    // released word must not look like the last one
    sf_word_o <= ~w;
    repeat (gap + 1) @(posedge clk_i);
  endtask : send
endmodule : sprx_src_model

`default_nettype wire

/* verif/tb_spdif_receiver_input_and_status.sv */
/*
 * tb_spdif_receiver_input_and_status: random self-checking bench.
 * Assumes the source model and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, x, m) begin comparisons++; if ((a) !== (x)) begin \
  failures++; $display("wrong value at %0t: %s", $time, m); end end

module tb_spdif_receiver_input_and_status;
  import sprx_pkg::*;
  logic clk_i, srst_i, reg_we_i, reg_re_i, sf_valid_i, sf_chan2_i;
  logic sf_block_i, primary_comp_en_o, rx_enable_o, rx_line_o, sf_ready_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [3:0] pins;
  logic [2:0] multi_pin_rx_en_o, multi_pin_comp_en_o;
  logic [31:0] sf_word_i, aif_data_o;
  logic [1:0] aif_len_i;
  logic route_dac_i, out_valid_o, out_ready_i, out_chan2_o, validity_o;
  logic user_bit_o, parity_err_o, dac_mute_o, dac_pre_emphasis_flag_o, status_update_o;
  logic [23:0] dac_data_o, tx_data_o;
  logic [39:0] cur_cs, prev_cs, cs;
  logic [24:0] q[$];
  logic [24:0] e;
  logic pwr, mask, stall, have_prev;
  int failures, comparisons, cycles, n;

  sprx_core i_dut (.clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
    .reg_re_i, .reg_rdata_o, .primary_rx_input_i(pins[0]),
    .second_rx_input_i(pins[1]), .third_rx_input_i(pins[2]),
    .fourth_rx_input_i(pins[3]), .primary_comp_en_o, .multi_pin_rx_en_o,
    .multi_pin_comp_en_o, .rx_enable_o, .rx_line_o, .sf_valid_i, .sf_word_i,
    .sf_chan2_i, .sf_block_i, .sf_ready_o, .route_dac_i, .aif_len_i,
    .out_valid_o, .out_ready_i, .out_chan2_o, .dac_data_o, .aif_data_o,
    .tx_data_o, .validity_o, .user_bit_o, .parity_err_o, .dac_mute_o,
    .dac_pre_emphasis_flag_o, .status_update_o);
  sprx_src_model i_src (.clk_i, .sf_valid_o(sf_valid_i),
    .sf_word_o(sf_word_i), .sf_chan2_o(sf_chan2_i), .sf_block_o(sf_block_i),
    .sf_ready_i(sf_ready_o));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    out_ready_i <= !stall && ($urandom_range(3) != 0);
    cycles++;
    if (out_valid_o && out_ready_i) begin
      e = q.size() ? q.pop_front() : 'x;
      `CHK({out_chan2_o, dac_data_o}, e, "sample")
      `CHK(tx_data_o, e[23:0], "transmit sample")
      `CHK(aif_data_o, aif_exp(e[23:0], aif_len_i), "aif sample")
    end
    // timeout last, so nothing runs after the verdict
    if (cycles == 40000) begin
      failures++;
      conclude();
    end
  end

  function automatic logic [23:0] trunc(input logic [23:0] s,
                                        input logic [39:0] c, input logic m);
    int k;
    case (c[35:33])
      3'b001: k = 20;
      3'b010: k = 22;
      3'b100: k = 23;
      3'b101: k = 24;
      3'b110: k = 21;
      default: k = 0;
    endcase
    if (k == 0 || m) return s;
    if (!c[POS_CS_MAXLEN]) k = k - 4;
    return s & (24'hffffff << (24 - k));
  endfunction : trunc

  function automatic logic [31:0] aif_exp(input logic [23:0] s,
                                          input logic [1:0] l);
    int k;
    k = (l == AIF_LEN_32) ? 0 : 16 - 4 * l;
    return {s, 8'h00} & (32'hffffffff << k);
  endfunction : aif_exp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] x);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    @(posedge clk_i);
    `CHK(reg_rdata_o, x, "register read")
  endtask : rchk

  task automatic sf(input logic [23:0] s, input logic c2, input logic blk,
                    input logic cbit);
    logic [31:0] w;
    w = $urandom;
    w[SF_SAMPLE_HI:SF_SAMPLE_LO] = s;
    w[SF_CHSTAT] = cbit;
    if (pwr) q.push_back({c2, trunc(s, cur_cs, mask)});
    i_src.send(w, c2, blk, $urandom_range(2));
    if (pwr) begin
      `CHK(validity_o, w[SF_VALID], "validity")
      `CHK(user_bit_o, w[SF_USER], "user bit")
      `CHK(parity_err_o, ^w[31:4], "parity")
    end
  endtask : sf

  task automatic send_block(input logic [39:0] c);
    logic [23:0] s;
    for (int f = 0; f < CS_BITS; f++) begin
      s = 24'($urandom);
      if (f == 0) begin
        // low byte clear: entry may race the commit
        s[7:0] = 8'h00;
        if (have_prev) cur_cs = prev_cs;
      end
      sf(s, 1'b0, f == 0, c[f]);
      sf(24'($urandom), 1'b1, 1'b0, ~c[f]);
    end
    prev_cs = c;
    have_prev = 1'b1;
  endtask : send_block

  task automatic drain();
    n = 0;
    while ((q.size() != 0 || out_valid_o) && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(q.size(), 0, "queue drained")
  endtask : drain

  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i, pins} = '0;
    {route_dac_i, aif_len_i, out_ready_i, pwr, mask, have_prev} = '0;
    {cur_cs, prev_cs, failures, comparisons, cycles} = '0;
    stall = 1'b0;
    void'($urandom(32'h336b96ed));
    srst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    rchk(OFS_RX_INPUT_MODE, RST_RX_INPUT_MODE);
    rchk(OFS_PIN_CONFIG_C, RST_PIN_CONFIG_C);
    rchk(OFS_POWER_DOWN_B, RST_POWER_DOWN_B);
    wr(OFS_CS_BASE, 8'h5a);
    for (int a = OFS_CS_BASE; a <= OFS_CS_UPDATE; a++) begin
      rchk(8'(a), 8'h00);
    end
    rchk(8'h00, 8'h00);
    `CHK(primary_comp_en_o, 1'b1, "comparator default")
    `CHK(rx_enable_o, 1'b0, "receiver off")
    $display("test reset values done");
    wr(OFS_POWER_DOWN_B, 8'h00);
    wr(OFS_PIN_CONFIG_B, {CFG_RX_COMP, CFG_RX_CMOS});
    `CHK(rx_enable_o, 1'b1, "receiver on")
    wr(OFS_PIN_CONFIG_C, {4'h0, CFG_RX_COMP});
    rchk(OFS_PIN_CONFIG_B, {CFG_RX_COMP, CFG_RX_CMOS});
    `CHK(multi_pin_rx_en_o, 3'b111, "pin inputs")
    `CHK(multi_pin_comp_en_o, 3'b110, "pin comparators")
    for (int s = 0; s < 4; s++) begin
      wr(OFS_RX_INPUT_MODE, {5'h00, 2'(s), 1'b0});
      pins <= 4'h1 << s;
      repeat (4) @(posedge clk_i);
      `CHK(rx_line_o, 1'b1, "selected line high")
      pins <= ~(4'h1 << s);
      repeat (4) @(posedge clk_i);
      `CHK(rx_line_o, 1'b0, "selected line low")
    end
    `CHK(primary_comp_en_o, 1'b0, "cmos primary")
    wr(OFS_PIN_CONFIG_C, RST_PIN_CONFIG_C);
    pins <= 4'hf;
    repeat (4) @(posedge clk_i);
    `CHK(rx_line_o, 1'b0, "unconfigured pin")
    wr(OFS_POWER_DOWN_B, RST_POWER_DOWN_B);
    wr(OFS_RX_INPUT_MODE, 8'h41);
    repeat (4) @(posedge clk_i);
    `CHK(rx_line_o, 1'b0, "line while off")
    sf(24'h123456, 1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge clk_i);
    `CHK(out_valid_o, 1'b0, "dropped while off")
    $display("test input select done");
    wr(OFS_POWER_DOWN_B, 8'h00);
    pwr = 1'b1;
    mask = 1'b1;
    stall = 1'b1;
    n = 0;
    while (sf_ready_o && n < 12) begin
      sf(24'($urandom), 1'b1, 1'b0, 1'b0);
      @(posedge clk_i);
      n++;
    end
    `CHK(sf_ready_o, 1'b0, "fifo refuses")
    `CHK(n >= FIFO_DEPTH, 1'b1, "fifo depth")
    stall = 1'b0;
    drain();
    $display("test fifo fill done");
    for (int k = 0; k < 17; k++) begin
      cs = 40'({$urandom, $urandom});
      cs[35:32] = {k[2:0], k[3]};
      mask = (k % 5 == 4);
      wr(OFS_RX_INPUT_MODE, {1'b0, mask, 5'h00, 1'b1});
      route_dac_i <= 1'($urandom_range(1));
      aif_len_i <= 2'($urandom_range(3));
      send_block(cs);
      drain();
      `CHK(status_update_o, 1'(k > 0), "update flag set")
      for (int i = 0; i < 5; i++) begin
        rchk(8'(OFS_CS_BASE + i), cur_cs[8*i +: 8]);
      end
      `CHK(dac_mute_o, route_dac_i && cur_cs[POS_CS_NONAUDIO], "mute")
      `CHK(dac_pre_emphasis_flag_o, route_dac_i && cur_cs[POS_CS_PREEMPH], "pre_emphasis_flag")
      rchk(OFS_CS_UPDATE, {7'h00, 1'(k > 0)});
      rchk(OFS_CS_UPDATE, 8'h00);
    end
    $display("test status blocks done");
    conclude();
  end
endmodule : tb_spdif_receiver_input_and_status

`default_nettype wire
